// *** verilog/isq_top.sv ***
// How it works
// - Eighteen parallel sections sample in rotation
// - Eighteen-to-one mux selects one 13-bit result
// - Each conversion lasts exactly eighteen clocks
// - Zero, autozero, calibrate, sample, 13 bits, transfer
// - Eighteen-phase sequence from one clock
// - Neighbour sections offset by one clock
// - Exactly one section samples each clock
// - Whole pattern repeats every eighteen clocks
// - Output word fourteen clocks after sample
// - Offset loop integrates reference-zero comparisons
// - Gain loops for MSB and LSB references
// - Only sampling comparator connected to input
// - Switch gates isolate idle sections
// - Output word changes on rising edge
// - Overrange forces all code bits high
// - Active-low enable high floats outputs
// - Calibration needs ten thousand clocks minimum
module isq_top
	import isq_pkg::*;
#(
	parameter int CAL_CYCLES = CAL_MIN_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Comparator decisions, one per section
	input wire logic [17:0] comp,
	// Output enable from capture logic
	input wire logic out_en_n,
	// Input switch and reference zero gates
	output logic [17:0] sample_gate,
	output logic [17:0] zero_gate,
	// Trial codes for the section DACs
	output logic [233:0] dac_code,
	// Correction values per section
	output logic [179:0] offset_trim,
	output logic [179:0] gain_msb_trim,
	output logic [179:0] gain_lsb_trim,
	// Parallel output word
	output logic [11:0] sample_code_bits,
	output logic overrange_flag,
	output logic out_of_range_pin,
	output logic data_oe,
	output logic data_valid,
	output logic [4:0] out_section,
	// Calibration status
	output logic cal_ready
);

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	logic [4:0] phase;
	logic [12:0] sec_result [NSEC];
	logic [NSEC-1:0] sec_ready;
	logic [NSEC-1:0] sec_sample;
	logic [NSEC-1:0] sec_zero;
	logic [NSEC-1:0] primed;
	logic [4:0] sel;
	logic [12:0] word;
	logic [CAL_CNT_W-1:0] cal_cnt;
	isq_cal_t cal_state;

	// ----------------------------------------
	// Phase generator
	// ----------------------------------------
	// Modulo-eighteen counter shared by every section
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			phase <= PH_RST;
		end else begin
			phase <= isq_next_phase(phase);
		end
	end

	// ----------------------------------------
	// Conversion sections
	// ----------------------------------------
	// One section per index, all running at once
	for (genvar i = 0; i < NSEC; i++) begin : g_sec
		isq_section #(
			.IDX(i)
		) u_sec (
			.clk(clk),
			.rst_n(rst_n),
			.phase(phase),
			.comp(comp[i]),
			.sample_gate(sec_sample[i]),
			.zero_gate(sec_zero[i]),
			.dac_code(dac_code[i*RES_W +: RES_W]),
			.result(sec_result[i]),
			.result_ready(sec_ready[i]),
			.offset_trim(offset_trim[i*TRIM_W +: TRIM_W]),
			.gain_msb_trim(gain_msb_trim[i*TRIM_W +: TRIM_W]),
			.gain_lsb_trim(gain_lsb_trim[i*TRIM_W +: TRIM_W])
		);
	end

	// Gates are flops inside the sections; exactly one sample gate is high
	assign sample_gate = sec_sample;
	assign zero_gate = sec_zero;

	// Marks sections whose input switch has closed since reset; older words are stale
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			primed <= '0;
		end else begin
			primed <= primed | sec_sample;
		end
	end

	// ----------------------------------------
	// Output multiplexer
	// ----------------------------------------
	// The section at its last decision step is the one to present
	assign sel = isq_step_of(phase, ST_BITL);
	assign word = sec_result[sel];

	// Word lands at the start of the transfer step, fourteen clocks after sampling
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sample_code_bits <= CODE_RST;
			overrange_flag <= 1'b0;
			out_of_range_pin <= 1'b0;
			data_valid <= 1'b0;
			out_section <= 5'h00;
		end else begin
			overrange_flag <= word[RES_W-1];
			out_of_range_pin <= word[RES_W-1];
			if (word[RES_W-1]) begin
				sample_code_bits <= CODE_FULL;
			end else begin
				sample_code_bits <= word[CODE_W-1:0];
			end
			data_valid <= sec_ready[sel] && primed[sel];
			out_section <= sel;
		end
	end

	// Drivers float while the active-low enable is high
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			data_oe <= 1'b0;
		end else begin
			data_oe <= !out_en_n;
		end
	end

	// ----------------------------------------
	// Power-up calibration
	// ----------------------------------------
	// Count running clocks until the loops have settled
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cal_cnt <= '0;
			cal_state <= ISQ_CAL_RUN;
			cal_ready <= 1'b0;
		end else begin
			case (cal_state)
				ISQ_CAL_RUN: begin
					if (cal_cnt == CAL_CNT_W'(CAL_CYCLES - 1)) begin
						cal_state <= ISQ_CAL_DONE;
						cal_ready <= 1'b1;
					end else begin
						cal_cnt <= CAL_CNT_W'(cal_cnt + 1'b1);
					end
				end
				ISQ_CAL_DONE: begin
					cal_ready <= 1'b1;
				end
				default: begin
					cal_state <= ISQ_CAL_RUN;
					cal_ready <= 1'b0;
				end
			endcase
		end
	end

endmodule

// *** verilog/isq_pkg.sv ***
package isq_pkg;

	// ----------------------------------------
	// Schedule geometry
	// ----------------------------------------
	localparam int NSEC = 18;
	localparam int STEPS = 18;
	localparam int PH_W = 5;
	localparam int RES_W = 13;
	localparam int CODE_W = 12;
	localparam int TRIM_W = 10;
	localparam int LATENCY = 14;

	// Local steps, counted from zero (step 0 is the first clock of a conversion)
	localparam logic [4:0] ST_ZERO = 5'h00;
	localparam logic [4:0] ST_AZ = 5'h01;
	localparam logic [4:0] ST_CAL = 5'h02;
	localparam logic [4:0] ST_SAMP = 5'h03;
	localparam logic [4:0] ST_BIT0 = 5'h04;
	localparam logic [4:0] ST_BITL = 5'h10;
	localparam logic [4:0] ST_XFER = 5'h11;
	localparam logic [4:0] PH_LAST = 5'h11;

	// ----------------------------------------
	// Reset values and codes
	// ----------------------------------------
	localparam logic [4:0] PH_RST = 5'h00;
	localparam logic [12:0] SAR_FIRST = 13'h1000;
	localparam logic [12:0] SAR_RST = 13'h0000;
	localparam logic signed [9:0] TRIM_RST = 10'sh000;
	localparam logic signed [9:0] TRIM_MAX = 10'sh1FF;
	localparam logic signed [9:0] TRIM_MIN = -10'sh1FF;
	localparam logic [11:0] CODE_FULL = 12'hFFF;
	localparam logic [11:0] CODE_RST = 12'h000;

	// ----------------------------------------
	// Calibration timing
	// ----------------------------------------
	localparam int CLK_MHZ = 50;
	localparam int CAL_MIN_CYC = 10000;
	localparam int CAL_CNT_W = 14;

	typedef enum logic {
		ISQ_CAL_RUN,
		ISQ_CAL_DONE
	} isq_cal_t;

	// Local step of a section, or section index that is at a given step
	function automatic logic [4:0] isq_step_of(input logic [4:0] phase, input logic [4:0] idx);
		int v;
		v = (int'(phase) + STEPS - int'(idx)) % STEPS;
		return 5'(v);
	endfunction

	// Next value of the phase counter
	function automatic logic [4:0] isq_next_phase(input logic [4:0] phase);
		return (phase == PH_LAST) ? PH_RST : 5'(phase + 5'h01);
	endfunction

	// Saturating one-step trim move
	function automatic logic signed [9:0] isq_trim_move(input logic signed [9:0] v,
		input logic down);
		if (down) begin
			return (v == TRIM_MIN) ? v : 10'(v - 10'sh001);
		end
		return (v == TRIM_MAX) ? v : 10'(v + 10'sh001);
	endfunction

endpackage

// *** verilog/isq_section.sv ***
module isq_section
	import isq_pkg::*;
#(
	parameter int IDX = 0
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Shared phase
	input wire logic [4:0] phase,
	// Comparator decision of this section
	input wire logic comp,
	// Switch and DAC controls
	output logic sample_gate,
	output logic zero_gate,
	output logic [12:0] dac_code,
	// Finished result
	output logic [12:0] result,
	output logic result_ready,
	// Correction values
	output logic signed [9:0] offset_trim,
	output logic signed [9:0] gain_msb_trim,
	output logic signed [9:0] gain_lsb_trim
);

	// ----------------------------------------
	// Local step
	// ----------------------------------------
	logic [4:0] step;
	logic [4:0] next_step;
	logic [3:0] pos;
	logic [12:0] next_dac;
	logic cal_msb;

	// Own step lags the shared phase by the section index
	assign step = isq_step_of(phase, 5'(IDX));
	assign next_step = isq_step_of(isq_next_phase(phase), 5'(IDX));
	assign pos = 4'(ST_BITL - step);

	// Gates follow the step that starts at the next edge
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sample_gate <= 1'b0;
			zero_gate <= 1'b0;
		end else begin
			sample_gate <= (next_step == ST_SAMP);
			zero_gate <= (next_step == ST_ZERO);
		end
	end

	// ----------------------------------------
	// Successive approximation
	// ----------------------------------------
	// Decide current bit, then raise the next lower trial bit
	always_comb begin
		next_dac = dac_code;
		// Outside the decision steps pos points past the word, except at step 0 where it wraps to bit 0, so leave it alone
		if (step >= ST_BIT0 && step <= ST_BITL) begin
			if (!comp) begin
				next_dac[pos] = 1'b0;
			end
			if (pos != 4'h0) begin
				next_dac[pos - 4'h1] = 1'b1;
			end
		end
	end

	// Trial register across the thirteen decision steps
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			dac_code <= SAR_RST;
		end else if (step == ST_SAMP) begin
			dac_code <= SAR_FIRST;
		end else if (step >= ST_BIT0 && step <= ST_BITL) begin
			dac_code <= next_dac;
		end
	end

	// Final word includes the last decision
	assign result = next_dac;
	assign result_ready = (step == ST_BITL);

	// ----------------------------------------
	// Offset and gain loops
	// ----------------------------------------
	// Offset integrates the comparator answer to reference zero
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			offset_trim <= TRIM_RST;
		end else if (step == ST_AZ) begin
			offset_trim <= isq_trim_move(offset_trim, comp);
		end
	end

	// Gain loops take turns between the two references
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cal_msb <= 1'b1;
			gain_msb_trim <= TRIM_RST;
			gain_lsb_trim <= TRIM_RST;
		end else if (step == ST_CAL) begin
			cal_msb <= !cal_msb;
			if (cal_msb) begin
				gain_msb_trim <= isq_trim_move(gain_msb_trim, comp);
			end else begin
				gain_lsb_trim <= isq_trim_move(gain_lsb_trim, comp);
			end
		end
	end

endmodule

// *** tb/isq_top_asserts.sv ***
module isq_top_asserts
	import isq_pkg::*;
#(
	parameter int CAL_CYCLES = CAL_MIN_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Watched pins
	input wire logic out_en_n,
	input wire logic [17:0] sample_gate,
	input wire logic [17:0] zero_gate,
	input wire logic [11:0] sample_code_bits,
	input wire logic overrange_flag,
	input wire logic out_of_range_pin,
	input wire logic data_oe,
	input wire logic data_valid,
	input wire logic [4:0] out_section,
	input wire logic cal_ready
);
	timeunit 1ns;
	timeprecision 1ns;
	// ----
	// Helpers
	// ----
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	logic [4:0] samp_idx;
	logic [15:0] cal_cnt;
	logic [17:0] rot1;
	assign rot1 = {sample_gate[16:0], sample_gate[17]};
	// Index of the sampling section
	always_comb begin
		samp_idx = 5'h00;
		for (int i = 0; i < NSEC; i++) begin
			if (sample_gate[i]) begin
				samp_idx = 5'(i);
			end
		end
	end
	// Cycles since reset release
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cal_cnt <= 16'h0000;
		end else if (cal_cnt != 16'hFFFF) begin
			cal_cnt <= cal_cnt + 16'h0001;
		end
	end
	sequence s_samp;
		|sample_gate;
	endsequence
	AST_ONE_SAMPLER: assert property ($past(rst_n) |-> $onehot(sample_gate))
		else $error("several sections sampling");
	AST_ROTATE: assert property (s_samp |=> sample_gate == $past(rot1))
		else $error("sampling did not move to next section");
	AST_PERIOD: assert property (s_samp |-> ##18 sample_gate == $past(sample_gate, 18))
		else $error("pattern period is not 18");
	AST_ZERO_LEAD: assert property (|zero_gate |-> ##3 sample_gate == $past(zero_gate, 3))
		else $error("sample step not 3 after zero step");
	AST_NO_OVERLAP: assert property ((sample_gate & zero_gate) == 18'h00000)
		else $error("section on input and zero at once");
	AST_LATENCY: assert property (s_samp |-> ##14 data_valid && out_section == $past(samp_idx, 14))
		else $error("word not 14 cycles after sample");
	AST_OVR_CODE: assert property (overrange_flag |-> sample_code_bits == CODE_FULL)
		else $error("overrange code not all ones");
	AST_OTR_PIN: assert property (out_of_range_pin == overrange_flag)
		else $error("overrange pins differ");
	AST_OE: assert property ($past(rst_n) |-> data_oe == !$past(out_en_n))
		else $error("drive enable wrong");
	AST_CAL: assert property (cal_ready == (cal_cnt >= 16'(CAL_CYCLES)))
		else $error("calibration ready at wrong cycle");
endmodule

bind isq_top isq_top_asserts #(.CAL_CYCLES(CAL_CYCLES)) i_chk (.clk, .rst_n, .out_en_n,
	.sample_gate, .zero_gate, .sample_code_bits, .overrange_flag, .out_of_range_pin, .data_oe,
	.data_valid, .out_section, .cal_ready);

// *** tb/isq_capture.sv ***
module isq_capture
	import isq_pkg::*;
(
	// Clock
	input wire logic clk,
	// Word from the device
	input wire logic [11:0] code,
	input wire logic ovr,
	input wire logic oe,
	input wire logic valid,
	input wire logic [4:0] sec,
	// Latched word
	output logic [12:0] word,
	output logic [4:0] wsec,
	output logic got
);
	timeunit 1ns;
	timeprecision 1ns;
	// Latch on rising edge only while driven
	always_ff @(posedge clk) begin
		got <= oe && valid;
		if (oe && valid) begin
			word <= {ovr, code};
			wsec <= sec;
		end
	end
endmodule

// *** tb/interleaved_sar_sequencer_tb.sv ***
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; \
	$display("Error %s expected %h seen %h", nm, e, g); end end
module interleaved_sar_sequencer_tb;
	import isq_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, rst_n, out_en_n, overrange_flag, out_of_range_pin, data_oe, data_valid;
	logic cal_ready, got;
	logic [17:0] comp, sample_gate, zero_gate;
	logic [233:0] dac_code;
	logic [179:0] offset_trim, gain_msb_trim, gain_lsb_trim;
	logic [11:0] sample_code_bits;
	logic [4:0] out_section, wsec;
	logic [12:0] word;
	logic [12:0] vin [NSEC];
	int n_mismatch, checks_done;
	isq_top #(.CAL_CYCLES(20)) i_dut (.clk, .rst_n, .comp, .out_en_n, .sample_gate,
		.zero_gate, .dac_code, .offset_trim, .gain_msb_trim, .gain_lsb_trim,
		.sample_code_bits, .overrange_flag, .out_of_range_pin, .data_oe, .data_valid,
		.out_section, .cal_ready);
	isq_capture i_cap (.clk, .code(sample_code_bits), .ovr(overrange_flag), .oe(data_oe),
		.valid(data_valid), .sec(out_section), .word, .wsec, .got);
	// Clock
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// Comparators: input at or above trial code
	always @(posedge clk) begin
		#1;
		for (int i = 0; i < NSEC; i++) begin
			comp[i] = vin[i] >= dac_code[13*i +: 13];
		end
	end
	// ----
	// Scenarios
	// ----
	task automatic t_cal();
		repeat (10) @(posedge clk);
		#1;
		`CHK("cal_ready", 1'b0, cal_ready)
		`CHK("data_valid", 1'b0, data_valid)
		repeat (15) @(posedge clk);
		#1;
		`CHK("cal_ready", 1'b1, cal_ready)
		`CHK("data_valid", 1'b1, data_valid)
	endtask
	// Offset trim moves one step per visit, each gain trim every second visit, while the comparator reads high
	task automatic t_trim();
		logic [9:0] off [NSEC];
		logic [9:0] msb [NSEC];
		logic [9:0] lsb [NSEC];
		for (int i = 0; i < NSEC; i++) begin
			off[i] = offset_trim[10*i +: 10];
			msb[i] = gain_msb_trim[10*i +: 10];
			lsb[i] = gain_lsb_trim[10*i +: 10];
		end
		repeat (36) @(posedge clk);
		#1;
		for (int i = 0; i < NSEC; i++) begin
			`CHK("offset_trim", 10'(off[i] - 10'h002), offset_trim[10*i +: 10])
			`CHK("gain_msb_trim", 10'(msb[i] - 10'h001), gain_msb_trim[10*i +: 10])
			`CHK("gain_lsb_trim", 10'(lsb[i] - 10'h001), gain_lsb_trim[10*i +: 10])
		end
	endtask
	task automatic t_codes(input logic [12:0] stp);
		logic [12:0] e;
		logic [4:0] prev;
		for (int i = 0; i < NSEC; i++) begin
			vin[i] = 13'(i * stp);
		end
		vin[0] = 13'h0FFF;
		vin[1] = 13'h1000;
		repeat (40) @(posedge clk);
		for (int n = 0; n < 36; n++) begin
			@(posedge clk);
			#1;
			e = vin[wsec];
			`CHK("captured", 1'b1, got)
			`CHK("word", e[12] ? 13'h1FFF : e, word)
			if (n > 0) begin
				`CHK("section", (prev == 5'h11) ? 5'h00 : 5'(prev + 5'h01), wsec)
			end
			prev = wsec;
		end
	endtask
	task automatic t_enable();
		out_en_n = 1'b1;
		repeat (2) @(posedge clk);
		#1;
		`CHK("data_oe", 1'b0, data_oe)
		`CHK("captured", 1'b0, got)
		out_en_n = 1'b0;
		repeat (2) @(posedge clk);
		#1;
		`CHK("data_oe", 1'b1, data_oe)
	endtask
	task automatic results();
		$display("Checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// Main sequence
	initial begin
		rst_n = 1'b0;
		out_en_n = 1'b0;
		n_mismatch = 0;
		checks_done = 0;
		for (int i = 0; i < NSEC; i++) begin
			vin[i] = 13'h0000;
		end
		repeat (6) @(posedge clk);
		#1;
		rst_n = 1'b1;
		t_cal();
		t_codes(13'h01C7);
		t_trim();
		t_enable();
		t_codes(13'h0133);
		results();
	end
endmodule
